// ---- cmtp_defines.vh ----
// constants shared by the memory-mode block and its lookup array
`ifndef CMTP_DEFINES_VH
`define CMTP_DEFINES_VH
`define CMTP_PDP_BITS 16384
`define CMTP_PDP_AW 14
`define CMTP_PDP_DW 32
`define CMTP_WSEL_W 3
`define CMTP_WSEL_1 3'h0
`define CMTP_WSEL_2 3'h1
`define CMTP_WSEL_4 3'h2
`define CMTP_WSEL_8 3'h3
`define CMTP_WSEL_16 3'h4
`define CMTP_WSEL_32 3'h5
`define CMTP_CAM_DEPTH 128
`define CMTP_CAM_AW 7
`define CMTP_CAM_DW 48
`define CMTP_CSEL_LOCAL 3'h0
`define CMTP_CSEL_G0 3'h1
`define CMTP_CSEL_G1 3'h2
`define CMTP_CSEL_G2 3'h3
`define CMTP_CSEL_G3 3'h4
`define CMTP_ESEL_LOCAL 2'h0
`define CMTP_ESEL_G1 2'h1
`define CMTP_ESEL_G2 2'h2
`define CMTP_PDP_INIT 32'h00000000
`define CMTP_CAM_INIT 48'h000000000000
`define CMTP_CAM_DC_INIT 48'h000000000000
`endif

// ---- cmtp_cam.v ----
// ternary lookup array: 128 entries of 48 bits with mask and don't-care
`timescale 1ns/1ps
`include "cmtp_defines.vh"
module cmtp_cam (
  input wire ref_clk,
  input wire memRst,
  input wire capStb,
  input wire [`CMTP_CAM_DW-1:0] camData,
  input wire [`CMTP_CAM_AW-1:0] camWrAddr,
  input wire camWrEn,
  input wire camCs,
  input wire camDontCare,
  input wire camMaskLoad,
  input wire camMaskEn,
  input wire [`CMTP_CAM_DEPTH-1:0] camCascVec,
  output reg camHit,
  output reg camMulti,
  output reg [`CMTP_CAM_AW-1:0] camLowAddr
);
  reg [`CMTP_CAM_DW-1:0] entVal [0:`CMTP_CAM_DEPTH-1];
  reg [`CMTP_CAM_DW-1:0] entDc [0:`CMTP_CAM_DEPTH-1];
  reg [`CMTP_CAM_DW-1:0] data_r;
  reg [`CMTP_CAM_DW-1:0] mask_r;
  reg [`CMTP_CAM_AW-1:0] addr_r;
  reg wrEn_r;
  reg cs_r;
  reg dc_r;
  reg stb_r;
  reg [`CMTP_CAM_DW-1:0] keep;
  reg [`CMTP_CAM_DW-1:0] care;
  integer e;
  integer n;

  // power-on contents, so the array can act as a fixed table
  initial begin
    for (n = 0; n < `CMTP_CAM_DEPTH; n = n + 1) begin
      entVal[n] = `CMTP_CAM_INIT;
      entDc[n] = `CMTP_CAM_DC_INIT;
    end
  end

  always @(posedge ref_clk or posedge memRst) begin
    if (memRst) begin
      data_r <= {`CMTP_CAM_DW{1'b0}};
      mask_r <= {`CMTP_CAM_DW{1'b0}};
      addr_r <= {`CMTP_CAM_AW{1'b0}};
      wrEn_r <= 1'b0;
      cs_r <= 1'b0;
      dc_r <= 1'b0;
      stb_r <= 1'b0;
    end else begin
      stb_r <= capStb;
      if (capStb) begin
        data_r <= camData;
        addr_r <= camWrAddr;
        wrEn_r <= camWrEn;
        cs_r <= camCs;
        dc_r <= camDontCare;
        if (camMaskLoad)
          mask_r <= camData;
      end
    end
  end

  // mask enable is used live, never latched
  always @* begin
    keep = camMaskEn ? mask_r : {`CMTP_CAM_DW{1'b0}};
  end

  // entries carry no reset, a reset leaves the table intact
  always @(posedge ref_clk) begin
    if (stb_r && wrEn_r && cs_r) begin
      entVal[addr_r] <= (entVal[addr_r] & keep) | (data_r & ~keep);
      entDc[addr_r] <= (entDc[addr_r] & keep) |
                       ({`CMTP_CAM_DW{dc_r}} & ~keep);
    end
  end

  // scan downward so the lowest matching entry is the one left
  always @* begin
    camHit = 1'b0;
    camMulti = 1'b0;
    camLowAddr = {`CMTP_CAM_AW{1'b0}};
    care = {`CMTP_CAM_DW{1'b0}};
    for (e = `CMTP_CAM_DEPTH - 1; e >= 0; e = e - 1) begin
      care = ~(entDc[e] | keep);
      if (cs_r && !wrEn_r && camCascVec[e] &&
          (((entVal[e] ^ data_r) & care) == {`CMTP_CAM_DW{1'b0}})) begin
        if (camHit)
          camMulti = 1'b1;
        camHit = 1'b1;
        camLowAddr = e[`CMTP_CAM_AW-1:0];
      end
    end
  end
endmodule

// ---- cmtp_mem_top.v ----
// memory-mode block: pseudo dual-port ram and ternary lookup array
`timescale 1ns/1ps
`include "cmtp_defines.vh"
module cmtp_mem_top (
  input wire ref_clk,
  input wire rst_n,
  input wire localRst,
  input wire localRstInv,
  input wire [3:0] globalClockNets,
  input wire writePortClock,
  input wire write_port_clock_enable,
  input wire [2:0] wrClkSel,
  input wire wrClkInv,
  input wire [1:0] wrCeSel,
  input wire wrCeInv,
  input wire readPortClock,
  input wire read_port_clock_enable,
  input wire [2:0] rdClkSel,
  input wire rdClkInv,
  input wire [1:0] rdCeSel,
  input wire rdCeInv,
  input wire [`CMTP_WSEL_W-1:0] wrWidthSel,
  input wire [`CMTP_WSEL_W-1:0] rdWidthSel,
  input wire [`CMTP_PDP_AW-1:0] wrAddr,
  input wire [`CMTP_PDP_DW-1:0] wrData,
  input wire wrEn,
  input wire wrEnInv,
  input wire wrCs,
  input wire wrCsInv,
  input wire [`CMTP_PDP_AW-1:0] rdAddr,
  input wire rdCs,
  input wire rdAddrReg,
  input wire rdDataReg,
  input wire camInClock,
  input wire camInEnable,
  input wire [2:0] camInClkSel,
  input wire camInClkInv,
  input wire [1:0] camInCeSel,
  input wire camInCeInv,
  input wire camOutClock,
  input wire camOutEnable,
  input wire [2:0] camOutClkSel,
  input wire camOutClkInv,
  input wire [1:0] camOutCeSel,
  input wire camOutCeInv,
  input wire camOutReg,
  input wire [`CMTP_CAM_DW-1:0] camData,
  input wire [`CMTP_CAM_AW-1:0] camWrAddr,
  input wire camWrEn,
  input wire camWrEnInv,
  input wire camCs,
  input wire camCsInv,
  input wire camDontCare,
  input wire camMaskLoad,
  input wire camMaskEn,
  input wire [`CMTP_CAM_DEPTH-1:0] camCascVec,
  output reg [`CMTP_PDP_DW-1:0] rdData_r,
  output reg [`CMTP_CAM_AW-1:0] camMatchAddr_r,
  output reg camMatch_r,
  output reg camMultiMatch_r
);
  reg pdpMem [0:`CMTP_PDP_BITS-1];
  reg [3:0] gPrev_r;
  reg wrClkPrev_r;
  reg rdClkPrev_r;
  reg camInPrev_r;
  reg camOutPrev_r;
  reg [`CMTP_PDP_AW-1:0] wrAddr_r;
  reg [`CMTP_PDP_DW-1:0] wrData_r;
  reg wrEn_r;
  reg wrCs_r;
  reg wrStb_r;
  reg [`CMTP_WSEL_W-1:0] wrWidth_r;
  reg [`CMTP_PDP_AW-1:0] rdAddr_r;
  reg [`CMTP_PDP_DW-1:0] rdWord;
  reg [`CMTP_PDP_AW-1:0] rdIdx;
  wire memRst;
  wire wrTick;
  wire wrCe;
  wire rdTick;
  wire rdCe;
  wire camInTick;
  wire camInCe;
  wire camOutTick;
  wire camOutCe;
  wire camHit;
  wire camMulti;
  wire [`CMTP_CAM_AW-1:0] camLowAddr;
  wire [`CMTP_PDP_DW-1:0] wrMask;
  wire [`CMTP_PDP_DW-1:0] rdMask;
  wire [`CMTP_PDP_AW-1:0] wrBase;
  wire [`CMTP_PDP_AW-1:0] rdBase;
  wire [`CMTP_PDP_AW-1:0] rdAddrUse;
  integer ni;
  integer wi;
  integer ri;
  // power-on word pattern, repeated across the whole array
  localparam [`CMTP_PDP_DW-1:0] PDP_INIT_PAT = `CMTP_PDP_INIT;

  // a selected clock is seen as a one-cycle pulse on its active edge
  function clkTick;
    input [2:0] sel;
    input inv;
    input loc;
    input locPrev;
    input [3:0] g;
    input [3:0] gp;
    reg cur;
    reg prv;
    begin
      case (sel)
        `CMTP_CSEL_LOCAL: begin
          cur = loc;
          prv = locPrev;
        end
        `CMTP_CSEL_G0: begin
          cur = g[0];
          prv = gp[0];
        end
        `CMTP_CSEL_G1: begin
          cur = g[1];
          prv = gp[1];
        end
        `CMTP_CSEL_G2: begin
          cur = g[2];
          prv = gp[2];
        end
        `CMTP_CSEL_G3: begin
          cur = g[3];
          prv = gp[3];
        end
        default: begin
          cur = 1'b0;
          prv = 1'b0;
        end
      endcase
      clkTick = (cur ^ inv) & ~(prv ^ inv);
    end
  endfunction

  // enable sources are levels, taken as they stand on each edge
  function ceLevel;
    input [1:0] sel;
    input inv;
    input loc;
    input [3:0] g;
    reg src;
    begin
      case (sel)
        `CMTP_ESEL_LOCAL: src = loc;
        `CMTP_ESEL_G1: src = g[1];
        `CMTP_ESEL_G2: src = g[2];
        default: src = 1'b0;
      endcase
      ceLevel = src ^ inv;
    end
  endfunction

  // width code n, for n from 0 to 5, means 2**n bits per word; codes 6 and 7 give 1 bit
  function [`CMTP_PDP_DW-1:0] widthMask;
    input [`CMTP_WSEL_W-1:0] sel;
    begin
      case (sel)
        `CMTP_WSEL_1: widthMask = 32'h00000001;
        `CMTP_WSEL_2: widthMask = 32'h00000003;
        `CMTP_WSEL_4: widthMask = 32'h0000000F;
        `CMTP_WSEL_8: widthMask = 32'h000000FF;
        `CMTP_WSEL_16: widthMask = 32'h0000FFFF;
        `CMTP_WSEL_32: widthMask = 32'hFFFFFFFF;
        default: widthMask = 32'h00000001;
      endcase
    end
  endfunction

  // word address scaled to a bit address; upper words wrap off the top
  function [`CMTP_PDP_AW-1:0] bitBase;
    input [`CMTP_PDP_AW-1:0] addr;
    input [`CMTP_WSEL_W-1:0] sel;
    reg [`CMTP_PDP_AW+5:0] wide;
    begin
      wide = {6'h00, addr} << sel;
      bitBase = wide[`CMTP_PDP_AW-1:0];
    end
  endfunction

  // local reset comes from routing and may be either polarity
  assign memRst = ~rst_n | (localRst ^ localRstInv);

  // each register group picks its own clock and enable source
  assign wrTick = clkTick(wrClkSel, wrClkInv, writePortClock, wrClkPrev_r,
                          globalClockNets, gPrev_r);
  assign wrCe = ceLevel(wrCeSel, wrCeInv, write_port_clock_enable,
                        globalClockNets);
  assign rdTick = clkTick(rdClkSel, rdClkInv, readPortClock, rdClkPrev_r,
                          globalClockNets, gPrev_r);
  assign rdCe = ceLevel(rdCeSel, rdCeInv, read_port_clock_enable,
                        globalClockNets);
  assign camInTick = clkTick(camInClkSel, camInClkInv, camInClock, camInPrev_r,
                             globalClockNets, gPrev_r);
  assign camInCe = ceLevel(camInCeSel, camInCeInv, camInEnable,
                           globalClockNets);
  assign camOutTick = clkTick(camOutClkSel, camOutClkInv, camOutClock,
                              camOutPrev_r, globalClockNets, gPrev_r);
  assign camOutCe = ceLevel(camOutCeSel, camOutCeInv, camOutEnable,
                            globalClockNets);

  // history clears on the global reset only, a local reset keeps it
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gPrev_r <= 4'h0;
      wrClkPrev_r <= 1'b0;
      rdClkPrev_r <= 1'b0;
      camInPrev_r <= 1'b0;
      camOutPrev_r <= 1'b0;
    end else begin
      gPrev_r <= globalClockNets;
      wrClkPrev_r <= writePortClock;
      rdClkPrev_r <= readPortClock;
      camInPrev_r <= camInClock;
      camOutPrev_r <= camOutClock;
    end
  end

  // write side: everything captured on the write tick, array written next cycle
  always @(posedge ref_clk or posedge memRst) begin
    if (memRst) begin
      wrAddr_r <= {`CMTP_PDP_AW{1'b0}};
      wrData_r <= {`CMTP_PDP_DW{1'b0}};
      wrEn_r <= 1'b0;
      wrCs_r <= 1'b0;
      wrStb_r <= 1'b0;
      wrWidth_r <= `CMTP_WSEL_1;
    end else begin
      wrStb_r <= wrTick & wrCe;
      if (wrTick && wrCe) begin
        wrAddr_r <= wrAddr;
        wrData_r <= wrData;
        wrEn_r <= wrEn ^ wrEnInv;
        wrCs_r <= wrCs ^ wrCsInv;
        wrWidth_r <= wrWidthSel;
      end
    end
  end

  assign wrMask = widthMask(wrWidth_r);
  assign wrBase = bitBase(wrAddr_r, wrWidth_r);
  assign rdMask = widthMask(rdWidthSel);
  assign rdAddrUse = rdAddrReg ? rdAddr_r : rdAddr;
  assign rdBase = bitBase(rdAddrUse, rdWidthSel);

  initial begin
    for (ni = 0; ni < `CMTP_PDP_BITS; ni = ni + 1)
      pdpMem[ni] = PDP_INIT_PAT[ni % `CMTP_PDP_DW];
  end

  // base is aligned to the word width, so OR-ing in the bit index is an add
  // bits above the port width are left untouched
  always @(posedge ref_clk) begin
    for (wi = 0; wi < `CMTP_PDP_DW; wi = wi + 1) begin
      if (wrStb_r && wrEn_r && wrCs_r && wrMask[wi])
        pdpMem[wrBase | wi[`CMTP_PDP_AW-1:0]] <= wrData_r[wi];
    end
  end

  // read word gathered bit by bit, so any width maps the same way
  always @* begin
    rdWord = {`CMTP_PDP_DW{1'b0}};
    rdIdx = {`CMTP_PDP_AW{1'b0}};
    for (ri = 0; ri < `CMTP_PDP_DW; ri = ri + 1) begin
      rdIdx = rdBase | ri[`CMTP_PDP_AW-1:0];
      rdWord[ri] = rdMask[ri] & pdpMem[rdIdx];
    end
  end

  // read side: unselected blocks drive zero so outputs can be OR-ed for depth
  always @(posedge ref_clk or posedge memRst) begin
    if (memRst) begin
      rdAddr_r <= {`CMTP_PDP_AW{1'b0}};
      rdData_r <= {`CMTP_PDP_DW{1'b0}};
    end else begin
      if (rdTick && rdCe)
        rdAddr_r <= rdAddr;
      if (!rdDataReg || (rdTick && rdCe))
        rdData_r <= rdCs ? rdWord : {`CMTP_PDP_DW{1'b0}};
    end
  end

  // write enable and select may be inverted; data, don't-care and mask pins stay in true form
  cmtp_cam u_cam (
    .ref_clk(ref_clk),
    .memRst(memRst),
    .capStb(camInTick & camInCe),
    .camData(camData),
    .camWrAddr(camWrAddr),
    .camWrEn(camWrEn ^ camWrEnInv),
    .camCs(camCs ^ camCsInv),
    .camDontCare(camDontCare),
    .camMaskLoad(camMaskLoad),
    .camMaskEn(camMaskEn),
    .camCascVec(camCascVec),
    .camHit(camHit),
    .camMulti(camMulti),
    .camLowAddr(camLowAddr)
  );

  // unregistered mode still goes through a flop, refreshed every cycle
  always @(posedge ref_clk or posedge memRst) begin
    if (memRst) begin
      camMatchAddr_r <= {`CMTP_CAM_AW{1'b0}};
      camMatch_r <= 1'b0;
      camMultiMatch_r <= 1'b0;
    end else if (!camOutReg || (camOutTick && camOutCe)) begin
      camMatchAddr_r <= camLowAddr;
      camMatch_r <= camHit;
      camMultiMatch_r <= camMulti;
    end
  end
endmodule

// ---- cmtp_mem_sva.sv ----
// port assertions for the memory-mode block
`timescale 1ns/1ps
module cmtp_mem_sva (
  input wire ref_clk,
  input wire rst_n,
  input wire localRst,
  input wire localRstInv,
  input wire readPortClock,
  input wire [2:0] rdClkSel,
  input wire rdClkInv,
  input wire rdCs,
  input wire rdDataReg,
  input wire camInClock,
  input wire [2:0] camInClkSel,
  input wire camInClkInv,
  input wire camOutClock,
  input wire [2:0] camOutClkSel,
  input wire camOutClkInv,
  input wire camOutReg,
  input wire camMaskEn,
  input wire [31:0] rdData_r,
  input wire [6:0] camMatchAddr_r,
  input wire camMatch_r,
  input wire camMultiMatch_r
);
  wire locRst = localRst ^ localRstInv;
  wire [8:0] camOut = {camMultiMatch_r, camMatch_r, camMatchAddr_r};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rdNoEdge;
    rdDataReg && rdClkSel == 3'h0 && !rdClkInv && !readPortClock && !locRst;
  endsequence
  sequence s_outNoEdge;
    camOutReg && camOutClkSel == 3'h0 && !camOutClkInv && !camOutClock && !locRst;
  endsequence
  // three quiet input cycles: no capture and no pending entry write
  sequence s_camIdle;
    (!camInClock && camInClkSel == 3'h0 && !camInClkInv && !camOutReg && !locRst
      && $stable(camMaskEn)) [*3];
  endsequence
  property p_rst_rd;
    locRst |=> rdData_r == 32'h0;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("read data kept in reset");
  property p_rst_cam;
    locRst ##1 locRst |-> camOut == 9'h0;
  endproperty
  a_rst_cam: assert property (p_rst_cam) else $error("lookup outputs kept in reset");
  property p_rst_rel;
    $rose(rst_n) |-> rdData_r == 32'h0 && camOut == 9'h0;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("outputs not clear at release");
  property p_multi;
    camMultiMatch_r |-> camMatch_r;
  endproperty
  a_multi: assert property (p_multi) else $error("multi flag without match");
  property p_rd_hold;
    s_rdNoEdge |=> locRst || $stable(rdData_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without tick");
  property p_cam_hold;
    s_outNoEdge |=> locRst || $stable(camOut);
  endproperty
  a_cam_hold: assert property (p_cam_hold) else $error("lookup out moved without tick");
  property p_cam_idle;
    s_camIdle |=> locRst || !$stable(camMaskEn) || $stable(camOut);
  endproperty
  a_cam_idle: assert property (p_cam_idle) else $error("lookup out moved while idle");
  property p_rdcs;
    !rdCs && !rdDataReg && !locRst |=> rdData_r == 32'h0;
  endproperty
  a_rdcs: assert property (p_rdcs) else $error("deselected read not zero");
endmodule
bind cmtp_mem_top cmtp_mem_sva chk_u (.ref_clk, .rst_n, .localRst, .localRstInv, .readPortClock,
  .rdClkSel, .rdClkInv, .rdCs, .rdDataReg, .camInClock, .camInClkSel, .camInClkInv,
  .camOutClock, .camOutClkSel, .camOutClkInv, .camOutReg, .camMaskEn, .rdData_r,
  .camMatchAddr_r, .camMatch_r, .camMultiMatch_r);

// ---- cmtp_fabric_src.sv ----
// fabric-side clock source: one-cycle pulse on request, idle low
`timescale 1ns/1ps
module cmtp_fabric_src (
  input wire ref_clk,
  input wire fire,
  output reg srcClk
);
  initial srcClk = 1'b0;
  // launched on the rising edge, so the block sees it one edge later
  always @(posedge ref_clk) begin
    srcClk <= fire;
  end
endmodule

// ---- cam_and_two_port_ram_tb.sv ----
// self-checking bench for the memory-mode block
`timescale 1ns/1ps
`include "cmtp_defines.vh"
module cam_and_two_port_ram_tb;
  reg ref_clk = 1'b0, rst_n = 1'b0, localRst = 1'b0, localRstInv = 1'b0, fire = 1'b0;
  reg [2:0] clkSel = 3'h0, wrWidthSel = 3'h0, rdWidthSel = 3'h0, ws, rs;
  reg [1:0] ceSel = 2'h0;
  reg clkInv = 1'b0, ceInv = 1'b0, sel;
  reg [13:0] wrAddr = 14'h0, rdAddr = 14'h0, a;
  reg [31:0] wrData = 32'h0;
  reg wrEn = 1'b0, wrEnInv = 1'b0, wrCs = 1'b0, wrCsInv = 1'b0;
  reg rdCs = 1'b1, rdAddrReg = 1'b0, rdDataReg = 1'b0, camOutReg = 1'b0;
  reg [47:0] camData = 48'h0, maskM = 48'h0, d;
  reg [6:0] camWrAddr = 7'h0;
  reg camWrEn = 1'b0, camWrEnInv = 1'b0, camCs = 1'b0, camCsInv = 1'b0;
  reg camDontCare = 1'b0, camMaskLoad = 1'b0, camMaskEn = 1'b0;
  reg [16383:0] memM;
  reg [47:0] entV [0:127];
  reg [47:0] entD [0:127];
  integer mismatches = 0, checksDone = 0, i, k, seed;
  wire src;
  wire [31:0] rdData_r;
  wire [6:0] camMatchAddr_r;
  wire camMatch_r, camMultiMatch_r;
  cmtp_fabric_src fab_u (.ref_clk, .fire, .srcClk(src));
  // local clocks and global net 0 follow the fabric pulse, so select 0 or 1 ticks alike
  cmtp_mem_top dut_u (.ref_clk, .rst_n, .localRst, .localRstInv,
    .globalClockNets({1'b0, ~ceInv, ~ceInv, src}), .writePortClock(src),
    .write_port_clock_enable(~ceInv), .wrClkSel(clkSel), .wrClkInv(clkInv), .wrCeSel(ceSel),
    .wrCeInv(ceInv), .readPortClock(src), .read_port_clock_enable(~ceInv), .rdClkSel(clkSel),
    .rdClkInv(clkInv), .rdCeSel(ceSel), .rdCeInv(ceInv), .wrWidthSel, .rdWidthSel, .wrAddr,
    .wrData, .wrEn, .wrEnInv, .wrCs, .wrCsInv, .rdAddr, .rdCs, .rdAddrReg, .rdDataReg,
    .camInClock(src), .camInEnable(~ceInv), .camInClkSel(clkSel), .camInClkInv(clkInv),
    .camInCeSel(ceSel), .camInCeInv(ceInv), .camOutClock(src), .camOutEnable(~ceInv),
    .camOutClkSel(clkSel), .camOutClkInv(clkInv), .camOutCeSel(ceSel), .camOutCeInv(ceInv),
    .camOutReg, .camData, .camWrAddr, .camWrEn, .camWrEnInv, .camCs, .camCsInv, .camDontCare,
    .camMaskLoad, .camMaskEn, .camCascVec({128{1'b1}}), .rdData_r, .camMatchAddr_r,
    .camMatch_r, .camMultiMatch_r);
  task endOfTest;
    if (mismatches == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input [47:0] got, input [47:0] exp);
    checksDone = checksDone + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // hold three more cycles: an inverted clock ticks one edge late
  task pulse;
    fire = 1'b1;
    @(negedge ref_clk);
    fire = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  task rndCfg;
    clkSel = 3'($urandom % 2);
    clkInv = 1'($urandom % 2);
    ceSel = 2'($urandom % 3);
    ceInv = 1'($urandom % 2);
  endtask
  function [31:0] rdExp(input [2:0] w, input [13:0] ad);
    integer b;
    rdExp = 32'h0;
    for (b = 0; b < (1 << w); b = b + 1) rdExp[b] = memM[((ad << w) + b) % 16384];
  endfunction
  function [8:0] camExp(input [47:0] cd);
    integer e, n;
    camExp = 9'h0;
    n = 0;
    for (e = 127; e >= 0; e = e - 1) begin
      if (((entV[e] ^ cd) & ~entD[e] & ~({48{camMaskEn}} & maskM)) == 48'h0) begin
        n = n + 1;
        camExp[6:0] = e[6:0];
      end
    end
    camExp[8:7] = {n > 1, n > 0};
  endfunction
  task wr(input [2:0] w, input [13:0] ad, input [31:0] wd, input en);
    integer b;
    rndCfg;
    wrWidthSel = w;
    wrAddr = ad;
    wrData = wd;
    sel = 1'($urandom % 2);
    wrEnInv = 1'($urandom % 2);
    wrCsInv = 1'($urandom % 2);
    wrEn = (en | sel) ^ wrEnInv;
    wrCs = (en | ~sel) ^ wrCsInv;
    pulse;
    wrEn = wrEnInv;
    if (en) for (b = 0; b < (1 << w); b = b + 1) memM[((ad << w) + b) % 16384] = wd[b];
  endtask
  task rd(input [2:0] w, input [13:0] ad);
    rdWidthSel = w;
    rdAddr = ad;
    @(negedge ref_clk);
    check(rdData_r & ((64'h1 << (1 << w)) - 1), rdExp(w, ad));
  endtask
  task cam(input we, input cs, input [6:0] ad, input [47:0] cd, input dc, input ld);
    integer b;
    reg [8:0] e;
    rndCfg;
    camWrEnInv = 1'($urandom % 2);
    camCsInv = 1'($urandom % 2);
    camWrEn = we ^ camWrEnInv;
    camCs = cs ^ camCsInv;
    camWrAddr = ad;
    camData = cd;
    camDontCare = dc;
    camMaskLoad = ld;
    camMaskEn = ($urandom % 3 == 0);
    pulse;
    e = (cs && !we) ? camExp(cd) : 9'h0;
    check({camMultiMatch_r, camMatch_r, camMatchAddr_r}, e);
    if (ld) maskM = cd;
    for (b = 0; b < 48; b = b + 1) begin
      if (cs && we && !(camMaskEn && maskM[b])) begin
        entV[ad][b] = cd[b];
        entD[ad][b] = dc;
      end
    end
    camCs = camCsInv;
    camMaskLoad = 1'b0;
  endtask
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    endOfTest;
  end
  initial begin
    seed = $urandom(69264);
    memM = {512{`CMTP_PDP_INIT}};
    for (i = 0; i < 128; i = i + 1) begin
      entV[i] = `CMTP_CAM_INIT;
      entD[i] = `CMTP_CAM_DC_INIT;
    end
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check({rdData_r, camMultiMatch_r, camMatch_r, camMatchAddr_r}, 48'h0);
    for (i = 0; i < 70; i = i + 1) begin
      ws = (i < 6) ? i[2:0] : 3'($urandom % 6);
      a = (i < 6) ? (14'h3FFF >> i) : 14'($urandom);
      rs = 3'($urandom % 6);
      wr(ws, a, $urandom, ($urandom % 4 != 0));
      rd(rs, 14'(((a << ws) % 16384) >> rs));
      rd(rs, 14'($urandom));
    end
    clkSel = 3'h0;
    clkInv = 1'b0;
    rdAddrReg = 1'b1;
    rdDataReg = 1'b1;
    camOutReg = 1'b1;
    rdWidthSel = 3'h5;
    rdAddr = 14'h1FF;
    pulse;
    pulse;
    check(rdData_r, rdExp(5, 14'h1FF));
    rdAddr = 14'h0;
    repeat (3) @(negedge ref_clk);
    check(rdData_r, rdExp(5, 14'h1FF));
    rdCs = 1'b0;
    rdDataReg = 1'b0;
    @(negedge ref_clk);
    check(rdData_r, 48'h0);
    rdCs = 1'b1;
    rdAddrReg = 1'b0;
    camOutReg = 1'b0;
    cam(0, 0, 7'h0, 48'h3, 0, 1);
    for (i = 0; i < 80; i = i + 1) begin
      d = 48'hA5A50F0F3C00 | ($urandom % 8);
      k = $urandom % 8;
      if (k < 3) cam(1, 1, 7'($urandom % 8), d, ($urandom % 6 == 0), 0);
      else if (k < 7) cam(0, ($urandom % 6 != 0), 0, d, 0, 0);
      else cam(0, 0, 0, 48'($urandom % 8), 0, 1);
    end
    cam(1, 1, 7'h7F, 48'h123456789ABC, 0, 0);
    cam(0, 1, 0, 48'h123456789ABC, 0, 0);
    cam(0, 1, 0, 48'hFFFFFFFFFFFF, 0, 0);
    cam(0, 0, 0, 48'h0, 0, 0);
    // registered outputs: first tick still shows the deselected result
    camOutReg = 1'b1;
    clkSel = 3'h0;
    clkInv = 1'b0;
    camMaskEn = 1'b0;
    camData = 48'h123456789ABC;
    camWrEn = camWrEnInv;
    camCs = ~camCsInv;
    pulse;
    check({camMultiMatch_r, camMatch_r, camMatchAddr_r}, 48'h0);
    pulse;
    check({camMultiMatch_r, camMatch_r, camMatchAddr_r}, camExp(48'h123456789ABC));
    camCs = camCsInv;
    camOutReg = 1'b0;
    localRstInv = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({rdData_r, camMultiMatch_r, camMatch_r, camMatchAddr_r}, 48'h0);
    localRstInv = 1'b0;
    maskM = 48'h0;
    @(negedge ref_clk);
    cam(0, 1, 0, 48'h123456789ABC, 0, 0);
    endOfTest;
  end
endmodule
